//--- test/sgf_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module sgf_adc_model (
  // clock
  input wire logic hclk,
  // rate request
  input wire logic fast,
  // samples
  output logic adc_valid,
  output logic [sgf_pkg::SAMPLE_W-1:0] adc_sample
);
  import sgf_pkg::*;
  initial begin
    adc_valid = 1'b0;
    adc_sample = '0;
  end
  // gap of 4 or 5 cycles gives a 6:5 ratio of sample rates without long runs
  task automatic send(input logic [SAMPLE_W-1:0] v);
    @(posedge hclk);
    adc_valid <= 1'b1;
    adc_sample <= v;
    @(posedge hclk);
    adc_valid <= 1'b0;
    // stale data is inverted so a late capture cannot pass
    adc_sample <= ~v;
    repeat (fast ? 3 : 4) @(posedge hclk);
  endtask : send
endmodule : sgf_adc_model
`default_nettype wire

//--- test/sgf_filter_chain_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sgf_filter_chain_asserts #(
  parameter int FIR_DEPTH = 6000
) (
  // clock, reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // stream
  input wire logic adc_valid,
  input wire logic adc_fast_rate,
  input wire logic [sgf_pkg::OUT_W-1:0] result_word,
  input wire logic result_valid,
  input wire logic fir_settling
);
  import sgf_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // cycles since a write was taken; reset counts as one, it restarts the window too
  logic [2:0] age_reg;
  logic [2:0] age_next;
  always_comb begin
    age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
    if (hsel && htrans[1] && hwrite && hready)
      age_next = 3'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      age_reg <= 3'h0;
    else
      age_reg <= age_next;
  end
  sequence s_rd;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  sequence s_st_rd;
    s_rd ##0 haddr[11:0] == ADDR_STATUS;
  endsequence
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state");
  property p_sext;
    result_word[31:23] == {9{result_word[23]}};
  endproperty
  a_sext: assert property (p_sext) else $error("no sign extension");
  property p_hold;
    !result_valid |-> $stable(result_word);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without valid");
  property p_rdata;
    !(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_status;
    s_st_rd |=> hrdata[SETTLE_BIT] == $past(fir_settling);
  endproperty
  a_status: assert property (p_status) else $error("status bit differs");
  property p_settle_end;
    $fell(fir_settling) |-> $past(adc_valid);
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("settled without sample");
  property p_settle_start;
    $rose(fir_settling) |-> age_reg < 3'h4;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settling unprompted");
  property p_rate;
    $changed(adc_fast_rate) |-> age_reg < 3'h4;
  endproperty
  a_rate: assert property (p_rate) else $error("rate changed unprompted");
endmodule : sgf_filter_chain_asserts
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sgf_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic adc_valid, adc_fast_rate, result_valid, fir_settling, irq;
  logic [31:0] haddr, hwdata, hrdata, result_word, last_res;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [SAMPLE_W-1:0] adc_sample;
  int error_cnt = 0;
  int check_count = 0;
  int n_res = 0;
  int cyc = 0;
  int res_cyc = 0;
  int res_gap = 0;
  logic [11:0] ra [7] = '{ADDR_CONV_CFG, ADDR_IIR_CFG, ADDR_EXT_RATE, ADDR_SETPOINT,
    ADDR_MODEL, ADDR_IRQ_MASK, 12'hFFC};
  logic [31:0] rv [7] = '{32'(CONV_CFG_RST), 32'(IIR_CFG_RST), 32'(EXT_RATE_RST),
    32'(SETPOINT_RST), 32'(MODEL_RST), 32'h0, 32'h0};
  logic [3:0] cd [3] = '{4'hC, 4'hB, 4'hD};
  int ln [3] = '{4, 10, 2};
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  sgf_filter_chain u_sgf_filter_chain (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .adc_valid(adc_valid), .adc_sample(adc_sample),
    .adc_fast_rate(adc_fast_rate), .result_word(result_word),
    .result_valid(result_valid), .fir_settling(fir_settling), .irq(irq));
  sgf_adc_model u_sgf_adc_model (.hclk(hclk), .fast(adc_fast_rate),
    .adc_valid(adc_valid), .adc_sample(adc_sample));
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (result_valid === 1'b1) begin
      last_res <= result_word;
      n_res <= n_res + 1;
      res_gap <= cyc - res_cyc;
      res_cyc <= cyc;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    // only the watchdog ends a wait for the slave
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  // two idle cycles let the stored value reach the registered outputs
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(posedge hclk);
  endtask : wr
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : rc
  function automatic longint iir_step(input longint a, input longint x, input int l);
    return a + (((x <<< FRAC_W) - a) >>> l);
  endfunction : iir_step
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    logic [31:0] q;
    logic [3:0] code;
    longint acc;
    longint x;
    int n0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc("reset", ra[i], rv[i]);
    chk("settle_rst", fir_settling, 1'b1);
    code = CONV_CFG_RST;
    for (int c = 0; c < 16; c++) begin
      // upper bits set on purpose: only the low nibble is the rate field
      wr(ADDR_CONV_CFG, 32'hA0 | 32'(c));
      if (4'(c) < RATE_RSV_FIRST)
        code = 4'(c);
      rc("rate", ADDR_CONV_CFG, 32'(code));
      chk("fast", adc_fast_rate, code == RATE_FAST);
    end
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CONV_CFG, 32'(cd[k]));
      chk("settling", fir_settling, 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      chk("st_busy", q[SETTLE_BIT], 1'b1);
      n0 = n_res;
      for (int i = 0; i < ln[k]; i++) u_sgf_adc_model.send(i[0] ? 24'h008234 : 24'hFFA234);
      chk("avg", last_res, 32'h1234);
      chk("avg_top", last_res >> 8, 32'h12);
      chk("count", 32'(n_res - n0), 32'h1);
      chk("settled", fir_settling, 1'b0);
      chk("fast_fir", adc_fast_rate, cd[k] == RATE_FAST);
    end
    wr(ADDR_MODEL, 32'(MODEL_MULTI));
    u_sgf_adc_model.send(24'h812345);
    chk("multi", last_res, 32'hFFFF8123);
    wr(ADDR_MODEL, 32'(MODEL_EXT));
    wr(ADDR_EXT_RATE, 32'(RATE_FAST));
    chk("ext_fast", adc_fast_rate, 1'b1);
    acc = 0;
    for (int l = 0; l < 10; l++) begin
      wr(ADDR_IIR_CFG, 32'(l < 9 ? l : 15));
      x = l[0] ? l * 1000 - 8388608 : 8388607 - l * 777;
      acc = iir_step(acc, x, l < 9 ? l : 8);
      u_sgf_adc_model.send(24'(x));
      chk("iir", last_res, 32'(acc >>> FRAC_W));
    end
    rc("lvl_cap", ADDR_IIR_CFG, 32'(LVL_MAX));
    chk("irq_masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h3);
    chk("irq_on", irq, 1'b1);
    wr(ADDR_IRQ_ST, 32'h3);
    chk("irq_clr", irq, 1'b0);
    rc("irq_st", ADDR_IRQ_ST, 32'h0);
    u_sgf_adc_model.send(24'h000010);
    chk("irq_new", irq, 1'b1);
    // high-resolution mode paces results on its own, independent of samples
    wr(ADDR_IIR_CFG, 32'h20);
    u_sgf_adc_model.send(24'h00ABCD);
    n0 = n_res;
    repeat (5700) @(posedge hclk);
    chk("hires_cnt", 32'(n_res - n0), 32'h2);
    // 42 to 56 us at a 20 ns clock
    chk("hires_gap", 32'(res_gap >= 2100 && res_gap <= 2800), 32'h1);
    chk("hires_val", last_res, 32'h0000ABCD);
    results();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    results();
  end
endmodule : tb_top
bind sgf_filter_chain sgf_filter_chain_asserts #(.FIR_DEPTH(FIR_DEPTH)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .adc_valid(adc_valid),
  .adc_fast_rate(adc_fast_rate), .result_word(result_word),
  .result_valid(result_valid), .fir_settling(fir_settling));
`default_nettype wire

//--- verilog/sgf_filter_chain.sv
// Operation
// [RL1] each raw converter value enters the chain as a signed 24-bit sample
// [RL2] consumers ignore low-order bits below the effective noise-free resolution
// [RL3] multisampling model outputs only the sixteen most significant sample bits
// [RL4] two filters, IIR low-pass and FIR, each enabled and configured at runtime
// [RL5] after power-up both filters are disabled until configuration enables them; here the reset standard model runs the FIR from reset
// [RL6] new filter settings are taken at any time without stopping sampling
// [RL7] IIR output equals old output plus input-minus-old divided by 2^level
// [RL8] filter level zero disables the IIR and passes samples unchanged
// [RL9] levels 1 to 8 give corners 0.11476 down to 0.00062 of update rate
// [RL10] FIR averages a set sample count; 15 at 15000/s notches 1 kHz
// [RL11] FIR output settles one data-rate period after reconfiguration
// [RL12] status byte bit 5 stays set while the FIR settles, cleared afterwards
// [RL13] data rate select is a 4-bit field in bits 0 to 3 of config byte
// [RL14] codes 0000 to 1101 select 2.5 Hz to 7500 Hz; 1110 and 1111 reserved
// [RL15] extended model: code sets FIR length only; 15000/s, code 1011 at 20000/s
// [RL16] high-resolution mode update period lies within about 42 to 56 us
// [RL17] IIR division is an arithmetic shift on a wide signed accumulator
// [RL18] filtered 24-bit result is sign-extended to the 32-bit output word
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module sgf_filter_chain #(
  parameter int FIR_DEPTH = 6000
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // converter sample stream
  input wire logic adc_valid,
  input wire logic [sgf_pkg::SAMPLE_W-1:0] adc_sample,
  output logic adc_fast_rate,
  // filtered result and events
  output logic [sgf_pkg::OUT_W-1:0] result_word,
  output logic result_valid,
  output logic fir_settling,
  output logic irq
);
  import sgf_pkg::*;

  if (FIR_DEPTH < FIR_MAX_LEN || FIR_DEPTH >= (1 << CNT_W)) begin : g_depth_chk
    $error("sgf_filter_chain: FIR_DEPTH out of range");
  end

  typedef struct packed {
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [1:0] model;
    logic [RATE_W-1:0] conv_code;
    logic [RATE_W-1:0] ext_code;
    logic [IIR_CFG_W-1:0] iir_cfg;
    logic [MS_W-1:0] setpoint;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [RATE_W+2:0] sig;
    logic settling;
    logic [CNT_W-1:0] ptr;
    logic [CNT_W-1:0] fill;
    logic [CNT_W-1:0] dec;
    logic signed [SUM_W-1:0] sum;
    logic signed [ACC_W-1:0] iir_acc;
    logic [PACE_W-1:0] pace;
    logic [OUT_W-1:0] result;
    logic res_valid;
    logic fast;
  } sgf_state_t;

  function automatic sgf_state_t sgf_rst_val();
    sgf_state_t s;
    s = '0;
    s.rdy = 1'b1;
    s.model = MODEL_RST;
    s.conv_code = CONV_CFG_RST;
    s.ext_code = EXT_RATE_RST;
    s.iir_cfg = IIR_CFG_RST; // [RL5]
    s.setpoint = SETPOINT_RST;
    return s;
  endfunction : sgf_rst_val

  sgf_state_t st_reg;
  sgf_state_t st_next;

  // sample memory; no reset, the fill count hides stale entries
  logic signed [SAMPLE_W-1:0] fir_buf [FIR_DEPTH];
  logic buf_we;
  logic signed [SAMPLE_W-1:0] buf_old;
  logic signed [SAMPLE_W-1:0] x;
  logic [RATE_W-1:0] eff_code;
  logic fir_on;
  logic hires;
  logic [LVL_W-1:0] lvl;
  logic [CNT_W-1:0] len;
  logic [RATE_W+2:0] sig_now;
  logic addr_ok;
  logic signed [SUM_W-1:0] sum_n;
  logic signed [SUM_W+RECIP_W:0] prod;
  logic signed [SAMPLE_W-1:0] fir_out;
  logic signed [ACC_W-1:0] x_acc;
  logic signed [ACC_W:0] iir_diff;
  logic signed [ACC_W:0] iir_sum;
  logic signed [ACC_W-1:0] acc_n;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [LVL_W-1:0] wr_lvl;

  assign buf_old = fir_buf[st_reg.ptr];

  always_comb begin
    st_next = st_reg;
    irq_set = '0;
    irq_clr = '0;
    buf_we = 1'b0;
    x = adc_sample; // [RL1]
    eff_code = (st_reg.model == MODEL_EXT) ? st_reg.ext_code : st_reg.conv_code;
    fir_on = (st_reg.model == MODEL_STD)
      || (st_reg.model == MODEL_EXT && st_reg.iir_cfg[FIR_EN_BIT]); // [RL4]
    hires = (st_reg.model == MODEL_EXT) && st_reg.iir_cfg[HIRES_BIT];
    lvl = (st_reg.model == MODEL_EXT) ? st_reg.iir_cfg[LVL_W-1:0] : '0;
    len = fir_len(eff_code); // [RL10]
    sig_now = {st_reg.model, fir_on, eff_code};
    sum_n = st_reg.sum;
    prod = '0;
    fir_out = x;
    x_acc = '0;
    iir_diff = '0;
    iir_sum = '0;
    acc_n = st_reg.iir_acc;
    wr_lvl = hwdata[LVL_W-1:0];
    st_next.res_valid = 1'b0;

    // bus: address phase captured, write data taken one cycle later
    addr_ok = hsel && htrans[1] && hready;
    st_next.wr_pend = addr_ok && hwrite;
    st_next.wr_addr = haddr[ADDR_W-1:0];
    st_next.rdy = 1'b1;
    st_next.resp = 1'b0;
    if (addr_ok && !hwrite) begin
      case (haddr[ADDR_W-1:0])
        ADDR_STATUS: st_next.rdata = 32'(st_reg.settling) << SETTLE_BIT; // [RL12]
        ADDR_RESULT: st_next.rdata = st_reg.result;
        ADDR_CONV_CFG: st_next.rdata = 32'(st_reg.conv_code);
        ADDR_IIR_CFG: st_next.rdata = 32'(st_reg.iir_cfg);
        ADDR_EXT_RATE: st_next.rdata = 32'(st_reg.ext_code);
        ADDR_SETPOINT: st_next.rdata = 32'(st_reg.setpoint);
        ADDR_MODEL: st_next.rdata = 32'(st_reg.model);
        ADDR_IRQ_ST: st_next.rdata = 32'(st_reg.irq_st);
        ADDR_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
        default: st_next.rdata = '0;
      endcase
    end
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        ADDR_CONV_CFG: begin
          if (hwdata[RATE_W-1:0] < RATE_RSV_FIRST) begin
            st_next.conv_code = hwdata[RATE_W-1:0]; // [RL13] [RL14]
          end
        end
        ADDR_EXT_RATE: begin
          if (hwdata[RATE_W-1:0] < RATE_RSV_FIRST) begin
            st_next.ext_code = hwdata[RATE_W-1:0]; // [RL15]
          end
        end
        ADDR_IIR_CFG: begin
          // levels above the top corner are clamped to it
          st_next.iir_cfg = {hwdata[HIRES_BIT], hwdata[FIR_EN_BIT],
            (wr_lvl > LVL_MAX) ? LVL_MAX : wr_lvl}; // [RL6] [RL9]
        end
        ADDR_SETPOINT: begin
          if (hwdata[MS_W-1:0] != '0) begin
            st_next.setpoint = hwdata[MS_W-1:0];
          end
        end
        ADDR_MODEL: begin
          if (hwdata[1:0] <= MODEL_EXT) begin
            st_next.model = hwdata[1:0];
          end
        end
        ADDR_IRQ_ST: irq_clr = hwdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: st_next.irq_mask = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // both converter rate groups share one length table; 1011 needs 20000/s
    st_next.fast = (eff_code == RATE_FAST); // [RL15]
    st_next.sig = sig_now;

    if (sig_now != st_reg.sig) begin
      // reconfiguration: refill the window while sampling keeps running
      st_next.ptr = '0;
      st_next.fill = '0;
      st_next.dec = '0;
      st_next.sum = '0;
      st_next.pace = '0;
      st_next.settling = fir_on; // [RL6] [RL11] [RL12]
    end else begin
      if (hires) begin
        // fixed pacing inside the allowed window instead of the setpoint formula
        if (st_reg.pace == PACE_W'(HIRES_CYC - 1)) begin
          st_next.pace = '0;
          st_next.result = OUT_W'(st_reg.iir_acc >>> FRAC_W); // [RL16] [RL18]
          st_next.res_valid = 1'b1;
          irq_set[IRQ_NEW] = 1'b1;
        end else begin
          st_next.pace = st_reg.pace + 1'b1; // [RL16]
        end
      end
      if (adc_valid) begin
        if (st_reg.model == MODEL_MULTI) begin
          st_next.result = {{(OUT_W - MS_W){x[SAMPLE_W-1]}},
            x[SAMPLE_W-1 -: MS_W]}; // [RL3]
          st_next.res_valid = 1'b1;
          irq_set[IRQ_NEW] = 1'b1;
        end else begin
          if (fir_on) begin
            // moving sum; the oldest entry only counts once the window is full
            sum_n = st_reg.sum + SUM_W'(x)
              - ((st_reg.fill == len) ? SUM_W'(buf_old) : '0); // [RL10]
            prod = sum_n * $signed({1'b0, fir_recip(eff_code)});
            fir_out = prod[RECIP_SHIFT +: SAMPLE_W];
            buf_we = 1'b1;
            st_next.sum = sum_n;
            st_next.ptr = (st_reg.ptr == len - 1'b1) ? '0 : st_reg.ptr + 1'b1;
            if (st_reg.fill != len) begin
              st_next.fill = st_reg.fill + 1'b1;
            end
            if (st_reg.settling && st_reg.fill == len - 1'b1) begin
              st_next.settling = 1'b0; // [RL11] [RL12]
              irq_set[IRQ_SETTLED] = 1'b1;
            end
          end
          x_acc = {{2{fir_out[SAMPLE_W-1]}}, fir_out, {FRAC_W{1'b0}}};
          iir_diff = {x_acc[ACC_W-1], x_acc} - {st_reg.iir_acc[ACC_W-1], st_reg.iir_acc};
          // both operands signed, otherwise the shift below degrades to a logical one
          iir_sum = $signed({st_reg.iir_acc[ACC_W-1], st_reg.iir_acc})
            + (iir_diff >>> lvl); // [RL17]
          acc_n = (lvl == '0) ? x_acc : iir_sum[ACC_W-1:0]; // [RL7] [RL8]
          if (st_reg.model == MODEL_EXT) begin
            st_next.iir_acc = acc_n;
            if (!hires) begin
              st_next.result = OUT_W'(acc_n >>> FRAC_W); // [RL18]
              st_next.res_valid = 1'b1;
              irq_set[IRQ_NEW] = 1'b1;
            end
          end else if (!fir_on || st_reg.dec == len - 1'b1) begin
            // standard model decimates to the selected data rate
            st_next.dec = '0;
            st_next.result = {{(OUT_W - SAMPLE_W){fir_out[SAMPLE_W-1]}}, fir_out}; // [RL18]
            st_next.res_valid = 1'b1;
            irq_set[IRQ_NEW] = 1'b1;
          end else begin
            st_next.dec = st_reg.dec + 1'b1; // [RL14]
          end
        end
      end
    end

    // a new event beats a clear in the same cycle
    st_next.irq_st = (st_reg.irq_st & ~irq_clr) | irq_set;
    st_next.irq = |(st_next.irq_st & st_next.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= sgf_rst_val();
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && buf_we) begin
      fir_buf[st_reg.ptr] <= x;
    end
  end

  assign hreadyout = st_reg.rdy;
  assign hresp = st_reg.resp;
  assign hrdata = st_reg.rdata;
  assign adc_fast_rate = st_reg.fast;
  assign result_word = st_reg.result;
  assign result_valid = st_reg.res_valid;
  assign fir_settling = st_reg.settling;
  assign irq = st_reg.irq;
endmodule : sgf_filter_chain
`default_nettype wire

//--- verilog/sgf_pkg.sv
`default_nettype none
package sgf_pkg;
  // widths
  localparam int SAMPLE_W = 24;
  localparam int OUT_W = 32;
  localparam int MS_W = 16;
  localparam int SUM_W = 37;
  localparam int FRAC_W = 8;
  localparam int ACC_W = SAMPLE_W + FRAC_W + 2;
  localparam int CNT_W = 13;
  localparam int ADDR_W = 12;
  localparam int IRQ_W = 2;
  localparam int RECIP_W = 33;
  localparam int RECIP_SHIFT = 32;
  localparam int FIR_MAX_LEN = 6000;

  // register indices; byte address is four times the index
  localparam int IDX_STATUS = 2;
  localparam int IDX_RESULT = 4;
  localparam int IDX_CONV_CFG = 16;
  localparam int IDX_IIR_CFG = 272;
  localparam int IDX_EXT_RATE = 273;
  localparam int IDX_SETPOINT = 274;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_RESULT = ADDR_W'(IDX_RESULT * 4);
  localparam logic [ADDR_W-1:0] ADDR_CONV_CFG = ADDR_W'(IDX_CONV_CFG * 4);
  localparam logic [ADDR_W-1:0] ADDR_IIR_CFG = ADDR_W'(IDX_IIR_CFG * 4);
  localparam logic [ADDR_W-1:0] ADDR_EXT_RATE = ADDR_W'(IDX_EXT_RATE * 4);
  localparam logic [ADDR_W-1:0] ADDR_SETPOINT = ADDR_W'(IDX_SETPOINT * 4);
  localparam logic [ADDR_W-1:0] ADDR_MODEL = 12'h800;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 12'h804;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h808;

  // fields
  localparam int RATE_W = 4;
  localparam int LVL_W = 4;
  localparam int FIR_EN_BIT = 4;
  localparam int HIRES_BIT = 5;
  localparam int IIR_CFG_W = 6;
  localparam int SETTLE_BIT = 5;
  localparam int IRQ_NEW = 0;
  localparam int IRQ_SETTLED = 1;
  localparam logic [LVL_W-1:0] LVL_MAX = 4'h8;
  localparam logic [RATE_W-1:0] RATE_RSV_FIRST = 4'hE;
  localparam logic [RATE_W-1:0] RATE_FAST = 4'hB;
  localparam logic [1:0] MODEL_STD = 2'h0;
  localparam logic [1:0] MODEL_MULTI = 2'h1;
  localparam logic [1:0] MODEL_EXT = 2'h2;

  // reset values
  localparam logic [RATE_W-1:0] CONV_CFG_RST = 4'hD;
  localparam logic [RATE_W-1:0] EXT_RATE_RST = 4'hD;
  localparam logic [IIR_CFG_W-1:0] IIR_CFG_RST = 6'h00;
  localparam logic [MS_W-1:0] SETPOINT_RST = 16'h2710;
  localparam logic [1:0] MODEL_RST = MODEL_STD;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int HIRES_PERIOD_NS = 50000;
  localparam int HIRES_CYC = HIRES_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PACE_W = 12;

  // averaging length in converter samples (15000/s, 20000/s for the fast code)
  function automatic logic [CNT_W-1:0] fir_len(input logic [RATE_W-1:0] code);
    case (code)
      4'h0: fir_len = 13'h1770;
      4'h1: fir_len = 13'h0BB8;
      4'h2: fir_len = 13'h05DC;
      4'h3: fir_len = 13'h03E8;
      4'h4: fir_len = 13'h0258;
      4'h5: fir_len = 13'h01F4;
      4'h6: fir_len = 13'h012C;
      4'h7: fir_len = 13'h00FA;
      4'h8: fir_len = 13'h0096;
      4'h9: fir_len = 13'h001E;
      4'hA: fir_len = 13'h000F;
      4'hB: fir_len = 13'h000A;
      4'hC: fir_len = 13'h0004;
      default: fir_len = 13'h0002;
    endcase
  endfunction : fir_len

  // round(2^32 / length), so the average is a multiply instead of a divide
  function automatic logic [RECIP_W-1:0] fir_recip(input logic [RATE_W-1:0] code);
    case (code)
      4'h0: fir_recip = 33'hAEC34;
      4'h1: fir_recip = 33'h15D868;
      4'h2: fir_recip = 33'h2BB0D0;
      4'h3: fir_recip = 33'h418937;
      4'h4: fir_recip = 33'h6D3A07;
      4'h5: fir_recip = 33'h83126F;
      4'h6: fir_recip = 33'hDA740E;
      4'h7: fir_recip = 33'h10624DD;
      4'h8: fir_recip = 33'h1B4E81B;
      4'h9: fir_recip = 33'h8888889;
      4'hA: fir_recip = 33'h11111111;
      4'hB: fir_recip = 33'h1999999A;
      4'hC: fir_recip = 33'h40000000;
      default: fir_recip = 33'h80000000;
    endcase
  endfunction : fir_recip
endpackage : sgf_pkg
`default_nettype wire
